// >>> shared/acnt_consts.svh
// register offsets, field positions and reset values of the counter block
`ifndef ACNT_CONSTS_SVH
`define ACNT_CONSTS_SVH
`define ACNT_OFS_IRQ_FLAGS   8'h0c
`define ACNT_OFS_CNT_LOW     8'h0e
`define ACNT_OFS_CNT_HIGH    8'h0f
`define ACNT_OFS_CONTROL     8'h10
`define ACNT_BIT_OVF_FLAG    0
`define ACNT_BIT_ON          0
`define ACNT_BIT_SRC_SEL     1
`define ACNT_BIT_SYNC_BYP    2
`define ACNT_BIT_OSC_EN      3
`define ACNT_BIT_PRESC_LO    4
`define ACNT_BIT_PRESC_HI    5
`define ACNT_CTRL_MASK       8'h3f
`define ACNT_CTRL_RESET      8'h00
`define ACNT_FLAGS_RESET     8'h00
`define ACNT_CNT_RESET       16'h0000
`endif

// >>> shared/acnt_pkg.sv
// types shared by the counter block
package acnt_pkg;
  typedef logic [15:0] acnt_count_t;
  typedef logic [7:0]  acnt_byte_t;
  typedef struct packed {
    logic [1:0] prescale;
    logic       osc_en;
    logic       sync_bypass;
    logic       src_sel;
    logic       on;
  } acnt_ctrl_s;
endpackage

// >>> shared/acnt_link_if.sv
// crossing signals between the register side and the link-clock counter
`timescale 1ns/1ps
`default_nettype none
interface acnt_link_if #(parameter int W = 16);
  logic         run;
  logic         load_tgl;
  logic [W-1:0] load_val;
  logic         load_ack;
  logic         snap_req;
  logic         snap_ack;
  logic [W-1:0] snap_val;
  logic         ovf_tgl;
  modport regs (output run, output load_tgl, output load_val,
                input load_ack, output snap_req, input snap_ack,
                input snap_val, input ovf_tgl);
  modport link (input run, input load_tgl, input load_val,
                output load_ack, input snap_req, output snap_ack,
                output snap_val, output ovf_tgl);
endinterface
`default_nettype wire

// >>> hw/acnt_link_counter.sv
// counter that runs on the external count clock, with its crossings
`timescale 1ns/1ps
`default_nettype none
`include "acnt_consts.svh"
module acnt_link_counter
  import acnt_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic count_clk,
  input  wire logic reset_n,
  acnt_link_if.link lk
);
  logic         rst_meta_q, rst_q;
  logic         run_meta_q, run_q;
  logic         ld_meta_q, ld_sync_q, ld_seen_q;
  logic         sr_meta_q, sr_sync_q, snap_ack_q;
  logic [W-1:0] cnt_q, snap_q;
  logic         ovf_q;
  wire          load_now;
  wire          wrap;

  // release of reset is retimed; the link clock may stand still
  always_ff @(posedge count_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  assign load_now = ld_sync_q ^ ld_seen_q;
  assign wrap     = run_q & (&cnt_q) & ~load_now;

  always_ff @(posedge count_clk or negedge rst_q) begin
    if (!rst_q) begin
      run_meta_q <= 1'b0;
      run_q      <= 1'b0;
      ld_meta_q  <= 1'b0;
      ld_sync_q  <= 1'b0;
      ld_seen_q  <= 1'b0;
      sr_meta_q  <= 1'b0;
      sr_sync_q  <= 1'b0;
      snap_ack_q <= 1'b0;
    end else begin
      run_meta_q <= lk.run;
      run_q      <= run_meta_q;
      ld_meta_q  <= lk.load_tgl;
      ld_sync_q  <= ld_meta_q;
      ld_seen_q  <= ld_sync_q;
      sr_meta_q  <= lk.snap_req;
      sr_sync_q  <= sr_meta_q;
      snap_ack_q <= sr_sync_q;
    end
  end

  // no synchronisation of the count clock itself
  always_ff @(posedge count_clk or negedge rst_q) begin
    if (!rst_q) begin
      cnt_q  <= W'(`ACNT_CNT_RESET);
      snap_q <= W'(`ACNT_CNT_RESET);
      ovf_q  <= 1'b0;
    end else begin
      if (load_now)
        cnt_q <= lk.load_val;
      else if (run_q)
        cnt_q <= cnt_q + W'(1);
      if (sr_sync_q != snap_ack_q)
        snap_q <= cnt_q;
      if (wrap)
        ovf_q <= ~ovf_q;
    end
  end

  assign lk.load_ack = ld_seen_q;
  assign lk.snap_ack = snap_ack_q;
  assign lk.snap_val = snap_q;
  assign lk.ovf_tgl  = ovf_q;
endmodule
`default_nettype wire

// >>> hw/acnt_top.sv
// sixteen-bit counter with register port and asynchronous count mode
`timescale 1ns/1ps
`default_nettype none
`include "acnt_consts.svh"
module acnt_top
  import acnt_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         count_clk,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic         sfr_wr,
  input  wire logic [7:0]   sfr_wdata,
  input  wire logic         sfr_rd,
  output logic      [7:0]   sfr_rdata,
  output logic              counter_overflow_flag,
  output logic              crystal_osc_enable,
  output logic              timebase_valid,
  output logic      [W-1:0] timebase_value
);
  // ****************************************************************
  // crossings from the link domain
  // ****************************************************************
  acnt_link_if #(.W(W)) lk ();

  acnt_link_counter #(.W(W)) u_link (
    .count_clk (count_clk),
    .reset_n   (reset_n),
    .lk        (lk)
  );

  // bit 0 load ack, 1 snapshot ack, 2 overflow toggle, 3 count pin
  logic [3:0] meta_q, sync_q, prev_q;
  wire  [3:0] async_in;
  wire  [3:0] changed;

  assign async_in = {count_clk, lk.ovf_tgl, lk.snap_ack, lk.load_ack};
  assign changed  = sync_q ^ prev_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ****************************************************************
  // control and mode decode
  // ****************************************************************
  acnt_ctrl_s   ctrl_q;
  logic         flag_q;
  acnt_count_t  cnt_q, snap_q, pend_q, load_q;
  logic         pend_valid_q, load_tgl_q, snap_req_q, async_q;
  logic [7:0]   rdata_q;

  wire async_mode = ctrl_q.sync_bypass & ctrl_q.src_sel;
  wire ext_rise   = sync_q[3] & ~prev_q[3];
  wire snap_done  = changed[1];
  wire link_ovf   = changed[2];
  wire load_busy  = load_tgl_q ^ sync_q[0];
  // request side idle once the returned ack matches it
  wire snap_idle  = ~(snap_req_q ^ sync_q[1]);
  wire enter_async = async_mode & ~async_q;
  wire leave_async = ~async_mode & async_q;

  // synchronised external clock or the core clock itself
  wire core_inc = ctrl_q.on & ~async_mode
                & (ctrl_q.src_sel ? ext_rise : 1'b1);
  wire core_wrap = core_inc & (&cnt_q);

  wire wr_ctrl  = sfr_wr & (sfr_addr == `ACNT_OFS_CONTROL);
  wire wr_flags = sfr_wr & (sfr_addr == `ACNT_OFS_IRQ_FLAGS);
  wire wr_low   = sfr_wr & (sfr_addr == `ACNT_OFS_CNT_LOW);
  wire wr_high  = sfr_wr & (sfr_addr == `ACNT_OFS_CNT_HIGH);
  wire wr_cnt   = wr_low | wr_high;

  // visible count: snapshot in async mode, live register otherwise
  wire acnt_count_t view = async_mode ? snap_q : cnt_q;
  // a second byte write merges onto a load not yet delivered; outside
  // async mode a leftover load must not leak into the live count
  wire acnt_count_t base = ~async_mode ? cnt_q
                         : pend_valid_q ? pend_q
                         : (load_busy ? load_q : snap_q);
  wire acnt_count_t merged = wr_low ? {base[15:8], sfr_wdata}
                                    : {sfr_wdata, base[7:0]};

  // only bits 5:0 exist; upper bits read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      ctrl_q <= acnt_ctrl_s'(6'(`ACNT_CTRL_RESET));
    else if (wr_ctrl)
      ctrl_q <= acnt_ctrl_s'(sfr_wdata[5:0]);
  end

  // ****************************************************************
  // overflow flag
  // ****************************************************************
  // a rollover in the clearing cycle still sets the flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      flag_q <= 1'(`ACNT_FLAGS_RESET);
    else if (core_wrap | link_ovf)
      flag_q <= 1'b1;
    else if (wr_flags)
      flag_q <= sfr_wdata[`ACNT_BIT_OVF_FLAG];
  end

  // ****************************************************************
  // core-domain counter (internal and synchronised modes)
  // ****************************************************************
  // a write beats an increment in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      cnt_q <= `ACNT_CNT_RESET;
    else if (leave_async)
      cnt_q <= snap_q;
    else if (wr_cnt & ~async_mode)
      cnt_q <= merged;
    else if (core_inc)
      cnt_q <= cnt_q + 16'h0001;
  end

  // ****************************************************************
  // load and snapshot handshakes to the link counter
  // ****************************************************************
  // load_q only changes while no load is in flight, so the link side
  // always samples settled data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q       <= `ACNT_CNT_RESET;
      pend_valid_q <= 1'b0;
      load_q       <= `ACNT_CNT_RESET;
      load_tgl_q   <= 1'b0;
      async_q      <= 1'b0;
    end else begin
      async_q <= async_mode;
      if (enter_async) begin
        pend_q       <= cnt_q;
        pend_valid_q <= 1'b1;
      end else if (wr_cnt & async_mode) begin
        pend_q       <= merged;
        pend_valid_q <= 1'b1;
      end else if (pend_valid_q & ~load_busy) begin
        load_q       <= pend_q;
        load_tgl_q   <= ~load_tgl_q;
        pend_valid_q <= 1'b0;
      end
    end
  end

  // snapshot requests run back to back; a stopped link clock just
  // leaves the last snapshot standing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_q     <= `ACNT_CNT_RESET;
      snap_req_q <= 1'b0;
    end else begin
      if (snap_done)
        snap_q <= lk.snap_val;
      if (snap_idle)
        snap_req_q <= ~snap_req_q;
    end
  end

  assign lk.run      = ctrl_q.on & async_mode;
  assign lk.load_tgl = load_tgl_q;
  assign lk.load_val = load_q;
  assign lk.snap_req = snap_req_q;

  // ****************************************************************
  // register read port
  // ****************************************************************
  wire [7:0] rd_mux =
      (sfr_addr == `ACNT_OFS_IRQ_FLAGS) ? {7'h00, flag_q} :
      (sfr_addr == `ACNT_OFS_CNT_LOW)   ? view[7:0] :
      (sfr_addr == `ACNT_OFS_CNT_HIGH)  ? view[15:8] :
      (sfr_addr == `ACNT_OFS_CONTROL)   ? {2'h0, 6'(ctrl_q)} :
                                          8'h00;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else if (sfr_rd)
      rdata_q <= rd_mux;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sfr_rdata             = rdata_q;
  assign counter_overflow_flag = flag_q;
  assign crystal_osc_enable    = ctrl_q.osc_en;
  assign timebase_valid        = ~async_mode;
  assign timebase_value        = cnt_q;
endmodule
`default_nettype wire

// >>> verification/acnt_top_chk.sv
// port-level assertion checker for the counter block
`timescale 1ns/1ps
`default_nettype none
module acnt_top_chk #(
  parameter int W = 16
) (
  input wire logic         core_clk,
  input wire logic         reset_n,
  input wire logic         count_clk,
  input wire logic [7:0]   sfr_addr,
  input wire logic         sfr_wr,
  input wire logic [7:0]   sfr_wdata,
  input wire logic         sfr_rd,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         counter_overflow_flag,
  input wire logic         crystal_osc_enable,
  input wire logic         timebase_valid,
  input wire logic [W-1:0] timebase_value
);
  // ********************
  // control mirror
  // ********************
  logic [7:0] ctl_q;
  logic [3:0] quiet_q;
  // quiet window lets mode-switch copies settle first
  wire sync_run  = quiet_q == 4'hf && ctl_q[1:0] == 2'b01;
  wire sync_stop = quiet_q == 4'hf && ctl_q[1:0] == 2'b00;
  wire unmapped  = !(sfr_addr inside {8'h0c, 8'h0e, 8'h0f, 8'h10});
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q   <= 8'h00;
      quiet_q <= 4'h0;
    end else if (sfr_wr) begin
      quiet_q <= 4'h0;
      if (sfr_addr == 8'h10) ctl_q <= sfr_wdata & 8'h3f;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  tbase_mode_a: assert property (timebase_valid == !(ctl_q[1] && ctl_q[2]))
    else $error("time base offered in async mode");
  osc_bit_a: assert property (crystal_osc_enable == ctl_q[3])
    else $error("oscillator enable differs from control");
  ctl_read_a: assert property (sfr_rd && sfr_addr == 8'h10 |=> sfr_rdata == $past(ctl_q))
    else $error("control readback wrong");
  unmapped_read_a: assert property (sfr_rd && unmapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  flag_read_a: assert property (sfr_rd && sfr_addr == 8'h0c |=> sfr_rdata[7:1] == 7'h00)
    else $error("flag register spare bits set");
  hold_off_a: assert property (sync_stop && !sfr_wr |=> $stable(timebase_value))
    else $error("stopped counter moved");
  count_step_a: assert property (sync_run && !sfr_wr |=> timebase_value - $past(timebase_value) == W'(1))
    else $error("running counter did not step by one");
  ovf_set_a: assert property (sync_run && timebase_value == '1 |-> ##[1:2] counter_overflow_flag)
    else $error("rollover did not set flag");
  flag_hold_a: assert property (counter_overflow_flag && !(sfr_wr && sfr_addr == 8'h0c) |=> counter_overflow_flag)
    else $error("overflow flag dropped");
  low_read_a: assert property (sync_stop && sfr_rd && sfr_addr == 8'h0e |=> sfr_rdata == timebase_value[7:0])
    else $error("low byte read wrong");
endmodule
bind acnt_top acnt_top_chk #(.W(W)) chk (.core_clk, .reset_n, .count_clk,
  .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .counter_overflow_flag,
  .crystal_osc_enable, .timebase_valid, .timebase_value);
`default_nettype wire

// >>> verification/acnt_clk_src.sv
// free-running external count clock source
`timescale 1ns/1ps
`default_nettype none
module acnt_clk_src (
  output var logic count_clk,
  output var int   edges
);
  // a crystal runs free, in sleep and reset alike
  initial begin
    count_clk = 1'b0;
    edges = 0;
    #3.3;
    forever begin
      #7.5;
      count_clk = ~count_clk;
      if (count_clk) edges++;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the counter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acnt_pkg::*;
  logic        core_clk, reset_n, sfr_wr, sfr_rd, count_clk;
  logic        counter_overflow_flag, crystal_osc_enable, timebase_valid;
  acnt_byte_t  sfr_addr, sfr_wdata, sfr_rdata, a, d, b;
  acnt_count_t timebase_value, v1, v2, dv;
  logic [31:0] lfsr_q;
  int          miscompares, comparisons, cycles, e;
  acnt_clk_src src (.count_clk(count_clk), .edges());
  acnt_top dut (.core_clk, .reset_n, .count_clk, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rd, .sfr_rdata, .counter_overflow_flag,
    .crystal_osc_enable, .timebase_valid, .timebase_value);
  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic bus(input logic w, input acnt_byte_t ad, input acnt_byte_t wd);
    @(posedge core_clk);
    #1;
    sfr_addr = ad;
    sfr_wdata = wd;
    sfr_wr = w;
    sfr_rd = !w;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    b = sfr_rdata;
  endtask
  // high, low, high again; reread when a carry slipped in
  task automatic read16(output acnt_count_t v);
    acnt_byte_t h;
    bus(1'b0, 8'h0f, 8'h00);
    h = b;
    bus(1'b0, 8'h0e, 8'h00);
    v = {h, b};
    bus(1'b0, 8'h0f, 8'h00);
    if (b !== h) begin
      bus(1'b0, 8'h0f, 8'h00);
      h = b;
      bus(1'b0, 8'h0e, 8'h00);
      v = {h, b};
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    lfsr_q = 32'h8593;
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    chk("tbase_valid", 16'h1, timebase_valid);
    bus(1'b0, 8'h10, 8'h00);
    chk("ctl_reset", 16'h0, b);
    bus(1'b0, 8'h0c, 8'h00);
    chk("flag_reset", 16'h0, b);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      d = (i == 0) ? 8'hff : lfsr_q[7:0];
      bus(1'b1, 8'h10, d);
      bus(1'b0, 8'h10, 8'h00);
      chk("ctl", d & 8'h3f, b);
      chk("osc_en", d[3], crystal_osc_enable);
      chk("tbase_valid", !(d[1] && d[2]), timebase_valid);
      a = lfsr_q[15:8] | 8'h20;
      bus(1'b1, a, lfsr_q[23:16]);
      bus(1'b0, a, 8'h00);
      chk("unmapped", 16'h0, b);
    end
    bus(1'b1, 8'h10, 8'h00);
    repeat (10) @(posedge core_clk);
    v1 = lfsr_q[31:16];
    bus(1'b1, 8'h0e, v1[7:0]);
    bus(1'b1, 8'h0f, v1[15:8]);
    repeat (20) @(posedge core_clk);
    read16(v2);
    chk("cnt_stopped", v1, v2);
    chk("tbase_value", v1, timebase_value);
    bus(1'b1, 8'h0c, 8'h00);
    bus(1'b1, 8'h0e, 8'he0);
    bus(1'b1, 8'h0f, 8'hff);
    bus(1'b1, 8'h10, 8'h01);
    repeat (40) @(posedge core_clk);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b0, 8'h0c, 8'h00);
    chk("ovf_flag", 16'h1, b);
    bus(1'b1, 8'h0c, 8'h00);
    bus(1'b0, 8'h0c, 8'h00);
    chk("ovf_clear", 16'h0, b);
    bus(1'b1, 8'h0e, 8'hf0);
    bus(1'b1, 8'h0f, 8'hff);
    bus(1'b1, 8'h10, 8'h07);
    repeat (200) @(posedge core_clk);
    e = src.edges;
    read16(v1);
    chk("tbase_valid", 16'h0, timebase_valid);
    repeat (300) @(posedge core_clk);
    e = src.edges - e;
    read16(v2);
    dv = v2 - v1;
    chk("async_delta", 16'h1, dv + 8 >= e && dv <= e + 8);
    bus(1'b0, 8'h0c, 8'h00);
    chk("async_ovf", 16'h1, b);
    finish_test();
  end
endmodule
`default_nettype wire
